// ### rtl/mms_core.sv
// Memory space map: program counter, return stack, data ROM window, pin sensing.
// Assumes a program memory with one-cycle registered read, pins arrive asynchronous.
`default_nettype none
`include "mms_defines.svh"
module mms_core #(
	parameter int STACK_DEPTH = `MMS_STACK_DEPTH
) (
	// Clock and control
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	// Pins
	input wire logic reset_pin_n_in,
	input wire logic nmi_pin_n_in,
	input wire logic vpp_high_in,
	// Core program flow
	input wire logic pc_load_in,
	input wire mms_pkg::mms_addr_t pc_load_val_in,
	input wire logic pc_inc_in,
	input wire logic call_in,
	input wire logic ret_in,
	output logic [`MMS_PC_W-1:0] program_counter_out,
	output logic stack_full_out,
	output logic stack_empty_out,
	// Data space access
	input wire logic data_wr_in,
	input wire logic data_rd_in,
	input wire mms_pkg::mms_byte_t data_addr_in,
	input wire mms_pkg::mms_byte_t data_wdata_in,
	output logic win_hit_out,
	output logic ram_sel_out,
	output logic reg_sel_out,
	// Program memory port
	output logic [`MMS_PC_W-1:0] pmem_addr_out,
	input wire mms_pkg::mms_byte_t pmem_rdata_in,
	output logic [`MMS_DADDR_W-1:0] win_rdata_out,
	// External readout and erase
	input wire logic ext_rd_in,
	input wire mms_pkg::mms_addr_t ext_addr_in,
	output logic ext_rd_ok_out,
	output logic [`MMS_DADDR_W-1:0] ext_rdata_out,
	input wire logic protect_set_in,
	input wire logic full_erase_in,
	output logic erase_all_out,
	output logic protected_out,
	// Events and modes
	output logic nmi_out,
	output logic core_reset_out,
	output logic prog_mode_out,
	// Ports
	output logic [`MMS_PORT_W-1:0] port_is_input_out,
	output logic [`MMS_PORT_W-1:0] port_pullup_out
);
	import mms_pkg::*;

	// The stack pointer is four bits wide, so deeper stacks cannot be counted
	if (STACK_DEPTH < 1 || STACK_DEPTH > 15) begin : g_depth_check
		$error("STACK_DEPTH out of range");
	end

	typedef struct packed {
		logic [2:0] rst_sync;
		logic [2:0] nmi_sync;
		logic [1:0] vpp_sync;
		mms_mode_t mode;
		mms_addr_t pc;
		logic [STACK_DEPTH-1:0][`MMS_PC_W-1:0] stk;
		logic [3:0] sp;
		logic [`MMS_WIN_OFS_W-1:0] wsel;
		logic protect;
		logic nmi;
		logic win_pend;
		logic ext_pend;
		mms_byte_t win_data;
		mms_byte_t ext_data;
		logic ext_ok;
		logic erase;
	} mms_state_t;

	mms_state_t st_r;
	mms_state_t st_nxt;
	logic pin_rst;
	logic win_rd;
	logic ext_allow;

	// Reset reads only the second stage, nmi the second and third; the first is metastability guard
	assign pin_rst = ~st_r.rst_sync[1];
	assign win_rd = data_rd_in && data_addr_in >= `MMS_WIN_LO && data_addr_in <= `MMS_WIN_HI;
	assign ext_allow = ext_rd_in && !st_r.protect;

	always_comb begin
		st_nxt = st_r;
		st_nxt.rst_sync = {st_r.rst_sync[1:0], reset_pin_n_in};
		st_nxt.nmi_sync = {st_r.nmi_sync[1:0], nmi_pin_n_in};
		st_nxt.vpp_sync = {st_r.vpp_sync[0], vpp_high_in};
		st_nxt.nmi = st_r.nmi_sync[2] && !st_r.nmi_sync[1];
		st_nxt.win_pend = 1'b0;
		st_nxt.ext_pend = 1'b0;
		st_nxt.erase = 1'b0;
		// Readout data shows only in the cycle after capture; refused or stale bytes read as zero
		st_nxt.ext_data = `MMS_BYTE_ZERO;
		if (pin_rst) begin
			// Pin reset overrides every other request; only sys_rst_in or a low clk_en_in can hold it off
			st_nxt.pc = `MMS_PC_RST;
			st_nxt.sp = '0;
			st_nxt.nmi = 1'b0;
			st_nxt.mode = (st_r.vpp_sync[1] == `MMS_VPP_HIGH) ? MMS_PROGRAM : MMS_IDLE;
		end else begin
			if (st_r.mode == MMS_IDLE) st_nxt.mode = MMS_NORMAL;
			if (call_in && st_r.sp < 4'(STACK_DEPTH)) begin
				st_nxt.stk[st_r.sp] = st_r.pc + 12'h001;
				st_nxt.sp = st_r.sp + 4'h1;
			end else if (ret_in && st_r.sp != 4'h0) begin
				st_nxt.sp = st_r.sp - 4'h1;
			end
			if (ret_in && !call_in && st_r.sp != 4'h0) st_nxt.pc = st_r.stk[st_r.sp - 4'h1];
			else if (pc_load_in) st_nxt.pc = pc_load_val_in;
			else if (pc_inc_in) st_nxt.pc = st_r.pc + 12'h001;
			if (data_wr_in && data_addr_in == `MMS_WSEL_ADDR) begin
				st_nxt.wsel = data_wdata_in[`MMS_WIN_OFS_W-1:0];
			end
			st_nxt.win_pend = win_rd;
			st_nxt.ext_pend = ext_allow;
			st_nxt.ext_ok = ext_allow;
			if (st_r.win_pend) st_nxt.win_data = pmem_rdata_in;
			if (st_r.ext_pend) st_nxt.ext_data = pmem_rdata_in;
			if (full_erase_in) begin
				st_nxt.protect = 1'b0;
				st_nxt.erase = 1'b1;
			end
			// A same-cycle set wins, so a racing erase never leaves the part open
			if (protect_set_in) st_nxt.protect = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st_r <= '0;
			st_r.rst_sync <= 3'b111;
			st_r.nmi_sync <= 3'b111;
			st_r.mode <= MMS_IDLE;
			st_r.wsel <= `MMS_WSEL_RST;
			st_r.protect <= 1'b1;
		end else if (clk_en_in) begin
			st_r <= st_nxt;
		end
	end

	// Window reads take the memory port ahead of fetch and external readout
	always_comb begin
		if (win_rd) pmem_addr_out = {st_r.wsel, data_addr_in[`MMS_WIN_OFS_W-1:0]};
		else if (ext_allow) pmem_addr_out = ext_addr_in;
		else pmem_addr_out = st_r.pc;
	end

	assign program_counter_out = st_r.pc;
	assign stack_full_out = st_r.sp == 4'(STACK_DEPTH);
	assign stack_empty_out = st_r.sp == 4'h0;
	assign win_hit_out = win_rd;
	assign ram_sel_out = data_addr_in <= `MMS_RAM_HI;
	assign reg_sel_out = data_addr_in >= `MMS_REG_LO;
	assign win_rdata_out = st_r.win_data;
	assign ext_rd_ok_out = st_r.ext_ok;
	assign ext_rdata_out = st_r.ext_data;
	assign erase_all_out = st_r.erase;
	assign protected_out = st_r.protect;
	assign nmi_out = st_r.nmi;
	assign core_reset_out = pin_rst || st_r.mode == MMS_IDLE;
	assign prog_mode_out = st_r.mode == MMS_PROGRAM;
	// Ports sit as input with pull-up until later port logic takes over
	assign port_is_input_out = ~`MMS_PORT_RST;
	assign port_pullup_out = ~`MMS_PORT_RST;

	a_nmi_edge: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && !pin_rst && st_r.nmi_sync[2] && !st_r.nmi_sync[1] |=> nmi_out)
		else $error("nmi not raised on falling edge");
	a_reset_pc: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && pin_rst |=> program_counter_out == `MMS_PC_RST && stack_empty_out)
		else $error("pin reset did not clear pc");
	a_win_addr: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		win_rd |-> pmem_addr_out[`MMS_WIN_OFS_W-1:0] == data_addr_in[`MMS_WIN_OFS_W-1:0])
		else $error("window offset wrong");
	a_win_range: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		data_rd_in && data_addr_in == `MMS_REG_LO |-> !win_hit_out)
		else $error("window hit outside range");
	a_protect_block: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && ext_rd_in && protected_out && !pin_rst |=> !ext_rd_ok_out)
		else $error("protected readout allowed");
	a_erase_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$fell(protected_out) |-> erase_all_out)
		else $error("protection cleared without erase");
	a_stack_bound: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		st_r.sp <= 4'(STACK_DEPTH))
		else $error("stack overflow");
	a_wsel_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && !pin_rst && data_wr_in && data_addr_in == `MMS_WSEL_ADDR
		|=> st_r.wsel == $past(data_wdata_in[`MMS_WIN_OFS_W-1:0]))
		else $error("window select not written");
	a_pc_inc: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && !pin_rst && pc_inc_in && !pc_load_in && !ret_in |=>
		program_counter_out == $past(program_counter_out) + 12'h001)
		else $error("pc did not increment");
	a_prog_mode: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && pin_rst && st_r.vpp_sync[1] |=> prog_mode_out)
		else $error("programming mode not entered");
endmodule : mms_core
`default_nettype wire

// ### include/mms_defines.svh
// Constants for the memory space map block: address ranges, widths, reset values.
// Assumes inclusion by bare name from the include path.
`ifndef MMS_DEFINES_SVH
`define MMS_DEFINES_SVH
`define MMS_PC_W 12
`define MMS_PC_RST 12'h000
`define MMS_STACK_DEPTH 6
`define MMS_DADDR_W 8
`define MMS_WIN_LO 8'h40
`define MMS_WIN_HI 8'h7F
`define MMS_WIN_OFS_W 6
`define MMS_WSEL_ADDR 8'hC9
`define MMS_WSEL_RST 6'h00
`define MMS_RAM_LO 8'h00
`define MMS_RAM_HI 8'h3F
`define MMS_REG_LO 8'h80
`define MMS_REG_HI 8'hFF
`define MMS_BYTE_ZERO 8'h00
`define MMS_PORT_W 12
`define MMS_PORT_RST 12'h000
`define MMS_VPP_HIGH 1'b1
`endif

// ### include/mms_pkg.sv
// Types for the memory space map block.
// Assumes mms_defines.svh is on the include path.
`default_nettype none
`include "mms_defines.svh"
package mms_pkg;
	typedef enum logic [1:0] {MMS_IDLE, MMS_NORMAL, MMS_PROGRAM} mms_mode_t;
	typedef logic [`MMS_PC_W-1:0] mms_addr_t;
	typedef logic [`MMS_DADDR_W-1:0] mms_byte_t;
endpackage : mms_pkg
`default_nettype wire

// ### test/test_mms_core.sv
// Self-checking bench for the memory space map core: seeded random and corner stimulus.
// Assumes mms_pkg is compiled first and mms_defines.svh is on the include path.
`default_nettype none
`include "mms_defines.svh"
module test_mms_core import mms_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_in = 0, sys_rst_in = 1, clk_en_in = 1, reset_pin_n_in = 1, nmi_pin_n_in = 1, vpp_high_in = 0;
	logic pc_load_in = 0, pc_inc_in = 0, call_in = 0, ret_in = 0, data_wr_in = 0, data_rd_in = 0;
	logic ext_rd_in = 0, protect_set_in = 0, full_erase_in = 0;
	mms_addr_t pc_load_val_in = 0, ext_addr_in = 0;
	mms_byte_t data_addr_in = 0, data_wdata_in = 0, pmem_rdata_in = 0;
	logic [11:0] program_counter_out, pmem_addr_out, port_is_input_out, port_pullup_out;
	logic [7:0] win_rdata_out, ext_rdata_out;
	logic stack_full_out, stack_empty_out, win_hit_out, ram_sel_out, reg_sel_out, ext_rd_ok_out;
	logic erase_all_out, protected_out, nmi_out, core_reset_out, prog_mode_out;
	int miscompares = 0, checks = 0, seed = 32'h4c76_ccbf;
	logic [7:0] ofs;
	logic [7:0] da [4] = '{8'h3F, 8'h40, 8'h7F, 8'h80};
	mms_addr_t stk [$];
	mms_core mms_core_i (.*);
	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Inputs always change 1 ns after the rising edge
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : tick
	task automatic conclude;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	function automatic logic [11:0] win_addr(input logic [7:0] blk, input logic [7:0] offset);
		return {blk[5:0], offset[5:0]};
	endfunction : win_addr
	function automatic logic in_win(input logic [7:0] addr);
		return addr >= `MMS_WIN_LO && addr <= `MMS_WIN_HI;
	endfunction : in_win
	initial forever #4 clk_in = ~clk_in;
	// Whole run needs about a hundred cycles; this limit leaves wide margin
	initial begin
		#20000;
		miscompares++;
		conclude();
	end
	initial begin
		tick(10);
		check("pc_rst", program_counter_out, 12'h000);
		check("port_in", port_is_input_out, 12'hFFF);
		check("port_pu", port_pullup_out, 12'hFFF);
		check("prot_rst", protected_out, 1);
		sys_rst_in = 0;
		tick(5);
		check("core_rst", core_reset_out, 0);
		data_wr_in = 1;
		data_addr_in = `MMS_WSEL_ADDR;
		data_wdata_in = 8'h00;
		tick();
		data_wr_in = 0;
		foreach (da[i]) begin
			data_rd_in = 1;
			data_addr_in = da[i];
			#1;
			check("ram_sel", ram_sel_out, da[i] <= 8'h3F);
			check("reg_sel", reg_sel_out, da[i] >= 8'h80);
			check("win_dec", win_hit_out, in_win(da[i]));
			tick();
		end
		data_rd_in = 0;
		for (int i = 0; i < 8; i++) begin
			ofs = i == 0 ? 8'h40 : i == 1 ? 8'h7F : 8'h40 | (8'($random(seed)) & 8'h3F);
			data_wr_in = 1;
			data_addr_in = `MMS_WSEL_ADDR;
			data_wdata_in = 8'($random(seed)) & 8'h3F;
			tick();
			data_wr_in = 0;
			data_rd_in = 1;
			data_addr_in = ofs;
			#1;
			check("win_hit", win_hit_out, 1);
			check("win_addr", pmem_addr_out, win_addr(data_wdata_in, ofs));
			tick();
			data_rd_in = 0;
			pmem_rdata_in = 8'($random(seed));
			tick();
			check("win_data", win_rdata_out, pmem_rdata_in);
		end
		// Calls are kept apart from loads since a call in the load cycle would push the old counter plus one
		for (int k = 0; k < 7; k++) begin
			pc_load_in = 1;
			pc_load_val_in = 12'($random(seed));
			tick();
			pc_load_in = 0;
			check("pc_load", program_counter_out, pc_load_val_in);
			check("full", stack_full_out, k == 6);
			check("empty", stack_empty_out, k == 0);
			if (k < 6) stk.push_back(pc_load_val_in + 12'h001);
			call_in = 1;
			tick();
			call_in = 0;
		end
		ret_in = 1;
		repeat (6) begin
			tick();
			check("ret_pc", program_counter_out, stk.pop_back());
		end
		ret_in = 0;
		check("empty_end", stack_empty_out, 1);
		pc_load_in = 1;
		pc_load_val_in = 12'hFFF;
		tick();
		pc_load_in = 0;
		pc_inc_in = 1;
		clk_en_in = 0;
		tick();
		check("pc_hold", program_counter_out, 12'hFFF);
		check("fetch_top", pmem_addr_out, 12'hFFF);
		clk_en_in = 1;
		tick();
		pc_inc_in = 0;
		check("pc_wrap", program_counter_out, 12'h000);
		check("fetch_pc", pmem_addr_out, 12'h000);
		ext_rd_in = 1;
		ext_addr_in = 12'($random(seed));
		tick();
		ext_rd_in = 0;
		check("ext_ok_p", ext_rd_ok_out, 0);
		tick();
		check("ext_dat_p", ext_rdata_out, 12'h000);
		full_erase_in = 1;
		tick();
		full_erase_in = 0;
		check("erase", erase_all_out, 1);
		check("unprot", protected_out, 0);
		tick();
		check("erase_end", erase_all_out, 0);
		ext_rd_in = 1;
		#1;
		check("ext_addr", pmem_addr_out, ext_addr_in);
		tick();
		ext_rd_in = 0;
		pmem_rdata_in = 8'($random(seed));
		check("ext_ok", ext_rd_ok_out, 1);
		tick();
		check("ext_dat", ext_rdata_out, pmem_rdata_in);
		protect_set_in = 1;
		tick();
		protect_set_in = 0;
		check("reprot", protected_out, 1);
		nmi_pin_n_in = 0;
		for (int n = 0; n < 6 && nmi_out !== 1'b1; n++) tick();
		check("nmi", nmi_out, 1);
		tick();
		check("nmi_end", nmi_out, 0);
		nmi_pin_n_in = 1;
		for (int v = 1; v >= 0; v--) begin
			vpp_high_in = v[0];
			reset_pin_n_in = 0;
			tick(4);
			check("pin_rst", core_reset_out, 1);
			reset_pin_n_in = 1;
			tick(5);
			vpp_high_in = 0;
			tick();
			check("prog", prog_mode_out, v[0]);
		end
		conclude();
	end
endmodule : test_mms_core
`default_nettype wire
